// ==== rtl/shfilt_pkg.sv ====
package shfilt_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned REG_W  = 16;
  localparam int unsigned TIME_W = 32;

  // ****************************************
  // attribute indices into the lower level
  // ****************************************
  localparam int unsigned ATTR_VOLT = 0;
  localparam int unsigned ATTR_CURR = 1;
  localparam int unsigned ATTR_TIME = 2;
  localparam int unsigned ATTR_TEMP = 3;
  localparam int unsigned ATTR_FAN  = 4;
  localparam int unsigned ATTR_BUS  = 5;
  localparam int unsigned N_ATTR    = 6;

  // questionable summary bit positions
  localparam int unsigned QS_VOLT = 0;
  localparam int unsigned QS_CURR = 1;
  localparam int unsigned QS_TIME = 2;
  localparam int unsigned QS_TEMP = 4;
  localparam int unsigned QS_FAN  = 5;
  localparam int unsigned QS_BUS  = 9;

  // bus attribute bit positions
  localparam int unsigned BUS_BERR   = 0;
  localparam int unsigned BUS_SYSF   = 1;
  localparam int unsigned BUS_ACF    = 2;
  localparam int unsigned BUS_IACK_LO = 3;
  localparam int unsigned N_IACK     = 7;

  // time attribute filter alarm bit, status byte bit
  localparam int unsigned TIME_FILT_BIT = 2;
  localparam int unsigned STB_QUES_BIT  = 3;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [REG_W-1:0]  ENA_RST    = 16'h0000;
  localparam logic [7:0]        SRE_RST    = 8'h00;
  localparam logic [TIME_W-1:0] LIMIT_RST  = 32'hffffffff;
  localparam int unsigned       CLK_HZ     = 40000000;
  localparam int unsigned       SEC_CYC    = CLK_HZ;

  // ****************************************
  // host command encodings
  // ****************************************
  typedef enum logic [3:0] {
    SHF_CMD_NONE       = 4'h0,
    SHF_CMD_READ_COND  = 4'h1,
    SHF_CMD_READ_EVENT = 4'h2,
    SHF_CMD_WRITE_ENA  = 4'h3,
    SHF_CMD_READ_ENA   = 4'h4,
    SHF_CMD_QCOND      = 4'h5,
    SHF_CMD_QEVENT     = 4'h6,
    SHF_CMD_QENA_WR    = 4'h7,
    SHF_CMD_QENA_RD    = 4'h8,
    SHF_CMD_SRE_WR     = 4'h9,
    SHF_CMD_STB_RD     = 4'ha,
    SHF_CMD_FLIM_SET   = 4'hb,
    SHF_CMD_FELAPSED   = 4'hc,
    SHF_CMD_FREF_CLR   = 4'hd,
    SHF_CMD_PON_RD     = 4'he
  } shf_cmd_t;

  // host command carrier
  typedef struct packed {
    logic              valid;
    shf_cmd_t          cmd;
    logic [2:0]        attr;
    logic [TIME_W-1:0] data;
  } shf_req_t;

  // answer carrier
  typedef struct packed {
    logic              valid;
    logic [TIME_W-1:0] data;
  } shf_rsp_t;

endpackage : shfilt_pkg

// ==== rtl/shfilt_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module shfilt_top
  import shfilt_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              power_on_i,
  input  wire logic [6:0]        volt_oot_i,
  input  wire logic [6:0]        curr_oot_i,
  input  wire logic [13:0]       temp_oot_i,
  input  wire logic [3:0]        fan_oot_i,
  input  wire logic [1:0]        time_oot_i,
  input  wire logic              berr_over_i,
  input  wire logic              sysfail_i,
  input  wire logic              acfail_i,
  input  wire logic [N_IACK-1:0] iack_over_i,
  input  wire shf_req_t          req_i,
  output var  shf_rsp_t          rsp_o,
  output logic                   irq_o,
  output logic                   filter_alarm_o
);

  // refuse a seconds divider the counter cannot serve
  if (SEC_CYCLES < 2) begin : g_bad_sec
    $error("SEC_CYCLES too small");
  end

  // ****************************************
  // condition assembly
  // ****************************************
  logic [REG_W-1:0] cond [N_ATTR];
  logic             alarm_ff;

  // present state of every item
  always_comb begin
    for (int a = 0; a < N_ATTR; a++) cond[a] = '0;
    cond[ATTR_VOLT][6:0]  = volt_oot_i;
    cond[ATTR_CURR][6:0]  = curr_oot_i;
    cond[ATTR_TEMP][13:0] = temp_oot_i;
    cond[ATTR_FAN][3:0]   = fan_oot_i;
    cond[ATTR_TIME][1:0]  = time_oot_i;
    // filter alarm into time bit 2
    cond[ATTR_TIME][TIME_FILT_BIT] = alarm_ff;
    cond[ATTR_BUS][BUS_BERR] = berr_over_i;
    cond[ATTR_BUS][BUS_SYSF] = sysfail_i;
    cond[ATTR_BUS][BUS_ACF]  = acfail_i;
    cond[ATTR_BUS][BUS_IACK_LO +: N_IACK] = iack_over_i;
  end

  // ****************************************
  // lower level: event / enable per attribute
  // ****************************************
  logic [REG_W-1:0] cond_ff [N_ATTR];
  logic [REG_W-1:0] evt_ff  [N_ATTR];
  logic [REG_W-1:0] ena_ff  [N_ATTR];
  logic [N_ATTR-1:0] summ;

  genvar g;
  generate
    for (g = 0; g < N_ATTR; g++) begin : g_attr
      logic [REG_W-1:0] nxt_cond;
      logic [REG_W-1:0] nxt_evt;
      logic [REG_W-1:0] nxt_ena;
      logic             rd_clr;
      logic             wr_ena;
      assign rd_clr = req_i.valid && req_i.cmd == SHF_CMD_READ_EVENT
                      && req_i.attr == 3'(g);
      assign wr_ena = req_i.valid && req_i.cmd == SHF_CMD_WRITE_ENA
                      && req_i.attr == 3'(g);

      // event latch and enable write
      always_comb begin
        nxt_cond = cond[g];
        nxt_evt  = rd_clr ? '0 : evt_ff[g];
        // rising edge sets, wins over clear
        nxt_evt  = nxt_evt | (cond[g] & ~cond_ff[g]);
        nxt_ena  = wr_ena ? req_i.data[REG_W-1:0] : ena_ff[g];
      end

      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cond_ff[g] <= '0;
          evt_ff[g]  <= '0;
          ena_ff[g]  <= ENA_RST;
        end else begin
          cond_ff[g] <= nxt_cond;
          evt_ff[g]  <= nxt_evt;
          ena_ff[g]  <= nxt_ena;
        end
      end

      assign summ[g] = |(evt_ff[g] & ena_ff[g]);

      a_evt_rise_only : assert property (@(posedge clk_i) disable iff (!nrst_i)
        (evt_ff[g] & ~$past(evt_ff[g])) ==
          ((evt_ff[g] & ~$past(evt_ff[g])) & ($past(cond[g]) & ~$past(cond_ff[g]))))
        else $error("event bit set without rising condition");
      a_evt_set_wins : assert property (@(posedge clk_i) disable iff (!nrst_i)
        (rd_clr && |(cond[g] & ~cond_ff[g])) |=> |evt_ff[g])
        else $error("event lost during read clear");
    end
  endgenerate

  // ****************************************
  // questionable level and status byte
  // ****************************************
  logic [REG_W-1:0] qcond;
  logic [REG_W-1:0] qcond_ff;
  logic [REG_W-1:0] qevt_ff;
  logic [REG_W-1:0] qena_ff;
  logic [7:0]       sre_ff;
  logic [7:0]       stb_ff;
  logic             irq_ff;
  logic [REG_W-1:0] nxt_qcond;
  logic [REG_W-1:0] nxt_qevt;
  logic [REG_W-1:0] nxt_qena;
  logic [7:0]       nxt_sre;
  logic [7:0]       nxt_stb;
  logic             nxt_irq;
  logic             qrd;

  assign qrd = req_i.valid && req_i.cmd == SHF_CMD_QEVENT;

  // summary placement and status byte
  always_comb begin
    qcond          = '0;
    qcond[QS_VOLT] = summ[ATTR_VOLT];
    qcond[QS_CURR] = summ[ATTR_CURR];
    qcond[QS_TIME] = summ[ATTR_TIME];
    qcond[QS_TEMP] = summ[ATTR_TEMP];
    qcond[QS_FAN]  = summ[ATTR_FAN];
    qcond[QS_BUS]  = summ[ATTR_BUS];
    nxt_qcond = qcond;
    // latch rise, clear on read, set wins
    nxt_qevt  = (qrd ? '0 : qevt_ff) | (qcond & ~qcond_ff);
    nxt_qena  = (req_i.valid && req_i.cmd == SHF_CMD_QENA_WR)
                ? req_i.data[REG_W-1:0] : qena_ff;
    nxt_sre   = (req_i.valid && req_i.cmd == SHF_CMD_SRE_WR)
                ? req_i.data[7:0] : sre_ff;
    nxt_stb   = '0;
    nxt_stb[STB_QUES_BIT] = |(qevt_ff & qena_ff);
    nxt_irq   = |(nxt_stb & ~stb_ff & sre_ff);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qcond_ff <= '0;
      qevt_ff  <= '0;
      qena_ff  <= ENA_RST;
      sre_ff   <= SRE_RST;
      stb_ff   <= '0;
      irq_ff   <= 1'b0;
    end else begin
      qcond_ff <= nxt_qcond;
      qevt_ff  <= nxt_qevt;
      qena_ff  <= nxt_qena;
      sre_ff   <= nxt_sre;
      stb_ff   <= nxt_stb;
      irq_ff   <= nxt_irq;
    end
  end

  a_stb_summary : assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 stb_ff[STB_QUES_BIT] == |($past(qevt_ff) & $past(qena_ff)))
    else $error("status byte bit 3 mismatch");
  a_irq_rise : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (sre_ff[STB_QUES_BIT] && !stb_ff[STB_QUES_BIT] && |(qevt_ff & qena_ff))
      |=> irq_ff)
    else $error("interrupt missing on rising status bit");

  // ****************************************
  // power-on clock and filter alarm
  // ****************************************
  logic [31:0]       tick_ff;
  logic [TIME_W-1:0] pon_ff;
  logic [TIME_W-1:0] ref_ff;
  logic [TIME_W-1:0] lim_ff;
  logic [31:0]       nxt_tick;
  logic [TIME_W-1:0] nxt_pon;
  logic [TIME_W-1:0] nxt_ref;
  logic [TIME_W-1:0] nxt_lim;
  logic              nxt_alarm;
  logic [TIME_W-1:0] elapsed;
  logic              sec_end;

  assign sec_end = tick_ff == 32'(SEC_CYCLES - 1);
  assign elapsed = pon_ff - ref_ff;

  // seconds counter, reference, limit
  always_comb begin
    nxt_tick = power_on_i ? (sec_end ? '0 : tick_ff + 32'd1) : tick_ff;
    nxt_pon  = (power_on_i && sec_end) ? pon_ff + 32'd1 : pon_ff;
    nxt_ref  = (req_i.valid && req_i.cmd == SHF_CMD_FREF_CLR) ? pon_ff : ref_ff;
    nxt_lim  = (req_i.valid && req_i.cmd == SHF_CMD_FLIM_SET)
               ? req_i.data : lim_ff;
    nxt_alarm = (nxt_pon - nxt_ref) >= nxt_lim;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_ff  <= '0;
      pon_ff   <= '0;
      ref_ff   <= '0;
      lim_ff   <= LIMIT_RST;
      alarm_ff <= 1'b0;
    end else begin
      tick_ff  <= nxt_tick;
      pon_ff   <= nxt_pon;
      ref_ff   <= nxt_ref;
      lim_ff   <= nxt_lim;
      alarm_ff <= nxt_alarm;
    end
  end

  a_alarm_limit : assert property (@(posedge clk_i) disable iff (!nrst_i)
    alarm_ff == ((pon_ff - ref_ff) >= lim_ff))
    else $error("filter alarm disagrees with limit");
  a_ref_clear : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (req_i.valid && req_i.cmd == SHF_CMD_FREF_CLR && !(power_on_i && sec_end))
      |=> elapsed == '0)
    else $error("elapsed not zero after reference clear");
  a_pon_step : assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 pon_ff == $past(pon_ff) + {31'd0, $past(power_on_i) && $past(sec_end)})
    else $error("power-on clock step wrong");

  // ****************************************
  // answers to queries
  // ****************************************
  shf_rsp_t nxt_rsp;
  shf_rsp_t rsp_ff;

  // read mux, registered
  always_comb begin
    nxt_rsp.valid = 1'b0;
    nxt_rsp.data  = '0;
    if (req_i.valid) begin
      nxt_rsp.valid = 1'b1;
      case (req_i.cmd)
        SHF_CMD_READ_COND:  nxt_rsp.data = 32'(cond_ff[req_i.attr]);
        SHF_CMD_READ_EVENT: nxt_rsp.data = 32'(evt_ff[req_i.attr]);
        SHF_CMD_READ_ENA:   nxt_rsp.data = 32'(ena_ff[req_i.attr]);
        SHF_CMD_QCOND:      nxt_rsp.data = 32'(qcond_ff);
        SHF_CMD_QEVENT:     nxt_rsp.data = 32'(qevt_ff);
        SHF_CMD_QENA_RD:    nxt_rsp.data = 32'(qena_ff);
        SHF_CMD_STB_RD:     nxt_rsp.data = 32'(stb_ff);
        SHF_CMD_FELAPSED:   nxt_rsp.data = elapsed;
        SHF_CMD_PON_RD:     nxt_rsp.data = pon_ff;
        default:            nxt_rsp.valid = 1'b0;
      endcase
      if (req_i.attr >= 3'(N_ATTR) && (req_i.cmd == SHF_CMD_READ_COND ||
          req_i.cmd == SHF_CMD_READ_EVENT || req_i.cmd == SHF_CMD_READ_ENA)) begin
        nxt_rsp.data = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign rsp_o          = rsp_ff;
  assign irq_o          = irq_ff;
  assign filter_alarm_o = alarm_ff;

endmodule : shfilt_top
`default_nettype wire

// ==== tb/shfilt_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// host side: one command at a time
// ****
module shfilt_host
  import shfilt_pkg::*;
(
  input  wire logic     clk_i,
  output var  shf_req_t req_o,
  input  wire shf_rsp_t rsp_i
);
  // idle request at time zero
  initial begin
    req_o = '0;
  end

  // issue on falling edge, drop after one taking edge, wait for answer
  task automatic xfer(input shf_cmd_t c, input logic [2:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    q = 'x;
    @(negedge clk_i);
    req_o = '{valid: 1'b1, cmd: c, attr: a, data: d};
    @(negedge clk_i);
    // idle lines show inverted last value
    req_o = '{valid: 1'b0, cmd: SHF_CMD_NONE, attr: ~a, data: ~d};
    for (int n = 0; n < 2; n++) begin
      if (rsp_i.valid === 1'b1) q = rsp_i.data;
      if (rsp_i.valid !== 1'b1) @(negedge clk_i);
    end
  endtask : xfer
endmodule : shfilt_host
`default_nettype wire

// ==== tb/shfilt_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) chk(a, e)
module shfilt_bench
  import shfilt_pkg::*;
;
  localparam int unsigned SEC = 4;
  typedef struct packed {
    logic [2:0]  attr;
    logic [15:0] v;
  } shfilt_row_t;

  logic              clk_i, nrst_i, power_on_i;
  logic [6:0]        volt_oot_i, curr_oot_i;
  logic [13:0]       temp_oot_i;
  logic [3:0]        fan_oot_i;
  logic [1:0]        time_oot_i;
  logic              berr_over_i, sysfail_i, acfail_i;
  logic [N_IACK-1:0] iack_over_i;
  shf_req_t          req;
  shf_rsp_t          rsp;
  logic              irq_o, filter_alarm_o;
  int                err_total, compares, cyc, irq_cnt;
  logic [31:0]       q, p0, p1;
  shfilt_row_t       rows [10] = '{
    '{3'd0, 16'h0040}, '{3'd1, 16'h0001}, '{3'd2, 16'h0002},
    '{3'd3, 16'h2000}, '{3'd4, 16'h0008}, '{3'd5, 16'h0001},
    '{3'd5, 16'h0002}, '{3'd5, 16'h0004}, '{3'd5, 16'h0008},
    '{3'd5, 16'h0200}};

  shfilt_top #(.SEC_CYCLES(SEC)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .power_on_i(power_on_i),
    .volt_oot_i(volt_oot_i), .curr_oot_i(curr_oot_i), .temp_oot_i(temp_oot_i),
    .fan_oot_i(fan_oot_i), .time_oot_i(time_oot_i), .berr_over_i(berr_over_i),
    .sysfail_i(sysfail_i), .acfail_i(acfail_i), .iack_over_i(iack_over_i),
    .req_i(req), .rsp_o(rsp), .irq_o(irq_o), .filter_alarm_o(filter_alarm_o));

  shfilt_host host (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));

  // ****
  // clock, timeout, interrupt count
  // ****
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (irq_o === 1'b1) irq_cnt++;
    if (cyc == 6000) begin
      err_total++;
      stop_test();
    end
  end

  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    compares++;
    if (a !== e) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk

  task automatic rd(input shf_cmd_t c, input logic [2:0] a, input logic [31:0] e);
    host.xfer(c, a, 32'h0, q);
    `CHK(q, e);
  endtask : rd

  task automatic wr(input shf_cmd_t c, input logic [2:0] a, input logic [31:0] d);
    host.xfer(c, a, d, q);
  endtask : wr

  // set one attribute's fault levels on a falling edge
  task automatic drive(input logic [2:0] a, input logic [15:0] v);
    @(negedge clk_i);
    case (a)
      3'd0: volt_oot_i = v[6:0];
      3'd1: curr_oot_i = v[6:0];
      3'd2: time_oot_i = v[1:0];
      3'd3: temp_oot_i = v[13:0];
      3'd4: fan_oot_i = v[3:0];
      default: begin
        berr_over_i = v[0];
        sysfail_i = v[1];
        acfail_i = v[2];
        iack_over_i = v[9:3];
      end
    endcase
  endtask : drive

  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // ****
  // main sequence
  // ****
  initial begin
    {nrst_i, volt_oot_i, curr_oot_i, temp_oot_i, fan_oot_i, time_oot_i} = '0;
    {berr_over_i, sysfail_i, acfail_i, iack_over_i} = '0;
    power_on_i = 1'b1;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) nrst_i = 1'b1;
    `CHK(filter_alarm_o, 1'b0);
    for (int a = 0; a < 6; a++) rd(SHF_CMD_READ_ENA, 3'(a), 32'h0);
    rd(SHF_CMD_QENA_RD, 3'd0, 32'h0);
    // one fault bit per row: rise, fall, latched, cleared
    foreach (rows[i]) begin
      drive(rows[i].attr, rows[i].v);
      repeat (3) @(negedge clk_i);
      rd(SHF_CMD_READ_COND, rows[i].attr, 32'(rows[i].v));
      drive(rows[i].attr, 16'h0);
      repeat (3) @(negedge clk_i);
      rd(SHF_CMD_READ_COND, rows[i].attr, 32'h0);
      rd(SHF_CMD_READ_EVENT, rows[i].attr, 32'(rows[i].v));
      rd(SHF_CMD_READ_EVENT, rows[i].attr, 32'h0);
    end
    // summary chain with only voltage bit 6 enabled
    wr(SHF_CMD_WRITE_ENA, 3'd0, 32'h40);
    wr(SHF_CMD_QENA_WR, 3'd0, 32'd32767);
    rd(SHF_CMD_QENA_RD, 3'd0, 32'h7fff);
    rd(SHF_CMD_READ_ENA, 3'd0, 32'h40);
    wr(SHF_CMD_SRE_WR, 3'd0, 32'h8);
    irq_cnt = 0;
    drive(3'd1, 16'h0001);
    drive(3'd0, 16'h0040);
    repeat (10) @(negedge clk_i);
    `CHK(irq_cnt, 1);
    rd(SHF_CMD_QCOND, 3'd0, 32'h1);
    rd(SHF_CMD_STB_RD, 3'd0, 32'h8);
    rd(SHF_CMD_QEVENT, 3'd0, 32'h1);
    rd(SHF_CMD_QEVENT, 3'd0, 32'h0);
    rd(SHF_CMD_STB_RD, 3'd0, 32'h0);
    // every attribute enabled and faulted
    for (int a = 0; a < 6; a++) wr(SHF_CMD_WRITE_ENA, 3'(a), 32'hffff);
    for (int a = 2; a < 6; a++) drive(3'(a), 16'h0001);
    repeat (6) @(negedge clk_i);
    rd(SHF_CMD_QCOND, 3'd0, 32'h0237);
    rd(SHF_CMD_READ_ENA, 3'd6, 32'h0);
    for (int a = 0; a < 6; a++) drive(3'(a), 16'h0);
    for (int a = 0; a < 6; a++) wr(SHF_CMD_READ_EVENT, 3'(a), 32'h0);
    // rise lands on the clearing read
    fork
      drive(3'd0, 16'h0001);
      wr(SHF_CMD_READ_EVENT, 3'd0, 32'h0);
    join
    rd(SHF_CMD_READ_EVENT, 3'd0, 32'h1);
    // filter timer with power frozen around each reading
    @(negedge clk_i) power_on_i = 1'b0;
    host.xfer(SHF_CMD_PON_RD, 3'd0, 32'h0, p0);
    // reference cleared as after a filter service
    wr(SHF_CMD_FREF_CLR, 3'd0, 32'h0);
    rd(SHF_CMD_FELAPSED, 3'd0, 32'h0);
    wr(SHF_CMD_FLIM_SET, 3'd0, 32'd3);
    repeat (12) @(negedge clk_i);
    `CHK(filter_alarm_o, 1'b0);
    power_on_i = 1'b1;
    repeat (30) @(negedge clk_i);
    power_on_i = 1'b0;
    repeat (3) @(negedge clk_i);
    host.xfer(SHF_CMD_PON_RD, 3'd0, 32'h0, p1);
    `CHK((p1 - p0) inside {[32'd6 : 32'd8]}, 1'b1);
    rd(SHF_CMD_FELAPSED, 3'd0, p1 - p0);
    `CHK(filter_alarm_o, 1'b1);
    rd(SHF_CMD_READ_COND, 3'd2, 32'h4);
    rd(SHF_CMD_READ_EVENT, 3'd2, 32'h4);
    rd(SHF_CMD_READ_EVENT, 3'd2, 32'h0);
    rd(SHF_CMD_READ_COND, 3'd2, 32'h4);
    wr(SHF_CMD_FREF_CLR, 3'd0, 32'h0);
    repeat (4) @(negedge clk_i);
    `CHK(filter_alarm_o, 1'b0);
    // mid-run reset with a voltage fault still standing
    @(negedge clk_i) nrst_i = 1'b0;
    @(negedge clk_i) nrst_i = 1'b1;
    `CHK(filter_alarm_o, 1'b0);
    rd(SHF_CMD_QENA_RD, 3'd0, 32'h0);
    rd(SHF_CMD_READ_EVENT, 3'd0, 32'h1);
    stop_test();
  end
endmodule : shfilt_bench
`default_nettype wire
